/* design/memmap_pkg.sv */
// Shared constants, types and decode helpers for the memory map decoder
package memmap_pkg;

  // ----------------------------------------------------------------
  // Program flash geometry
  // ----------------------------------------------------------------
  localparam int          FLASH_WORDS  = 32768;  // 64 KB of 16-bit words
  localparam int          FLASH_PAGES  = 128;
  localparam int          PAGE_BYTES   = 512;
  localparam int          WORD_AW      = 15;     // word address width
  localparam logic [15:0] CODE_BASE    = 16'h0000;

  // ----------------------------------------------------------------
  // Data space map
  // ----------------------------------------------------------------
  localparam logic [15:0] IO_END       = 16'h0fff;
  localparam logic [15:0] CFG_ADDR     = 16'h1000;
  localparam logic [15:0] SIG_BASE     = 16'h1100;
  localparam logic [15:0] SIG_END      = 16'h111f;
  localparam logic [15:0] EE_BASE      = 16'h1400;
  localparam logic [15:0] EE_END       = 16'h15ff;
  localparam logic [15:0] SRAM_BASE    = 16'h6000;
  localparam logic [15:0] SRAM_END     = 16'h7fff;
  localparam logic [15:0] WIN_BASE     = 16'h8000;
  localparam int          SRAM_BYTES   = 8192;

  // ----------------------------------------------------------------
  // Signature row offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [4:0]  SIG_ID0      = 5'h00;
  localparam logic [4:0]  SIG_ID1      = 5'h01;
  localparam logic [4:0]  SIG_ID2      = 5'h02;
  localparam logic [4:0]  SIG_TGAIN    = 5'h04;
  localparam logic [4:0]  SIG_TOFF     = 5'h06;
  localparam logic [4:0]  SIG_SER0     = 5'h10;
  localparam logic [4:0]  SIG_SER15    = 5'h1f;
  localparam logic        WIN_SEL_RST  = 1'b0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RG_NONE, RG_IO, RG_CFG, RG_SIG, RG_EE, RG_SRAM, RG_FLASH
  } region_t;

  typedef enum logic [1:0] {PR_BOOT, PR_APP, PR_DATA} prot_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LOCAL = 2'b01,
    ST_EXT   = 2'b10
  } acc_state_t;

  typedef struct packed {
    logic        code;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cpu_req_t;

  typedef struct packed {
    logic        io;
    logic        ee;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } ext_req_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic region_t decode(input logic [15:0] a);
    if (a <= IO_END)                        return RG_IO;
    else if (a == CFG_ADDR)                 return RG_CFG;
    else if (a >= SIG_BASE && a <= SIG_END) return RG_SIG;
    else if (a >= EE_BASE && a <= EE_END)   return RG_EE;
    else if (a >= SRAM_BASE && a <= SRAM_END) return RG_SRAM;
    else if (a >= WIN_BASE)                 return RG_FLASH;
    else                                    return RG_NONE;
  endfunction : decode

  // Lengths count 512-byte pages; boot first, then application code
  function automatic prot_t prot_region(input logic [6:0] page,
                                        input logic [7:0] boot_len,
                                        input logic [7:0] app_len);
    logic [8:0] app_end;
    app_end = {1'b0, boot_len} + {1'b0, app_len};
    if ({1'b0, page} < boot_len)          return PR_BOOT;
    else if ({2'b00, page} < app_end)     return PR_APP;
    else                                  return PR_DATA;
  endfunction : prot_region

endpackage : memmap_pkg

/* design/signature_rom.sv */
// Read-only factory signature row, 32 byte offsets
`timescale 1ns/1ps
module signature_rom #(
  parameter logic [23:0]  PART_ID  = 24'h00a5c3,   // Arbitrary value
  parameter logic [15:0]  TGAIN    = 16'h0100,     // Arbitrary value
  parameter logic [15:0]  TOFF     = 16'h0000,     // Arbitrary value
  parameter logic [127:0] SERIAL   = 128'h0        // Arbitrary value
) (
  input  wire logic [4:0] addr_i,  // Byte offset
  output logic      [7:0] data_o   // Byte at offset, zero if reserved
);

  // No write port exists, so content can never change
  always_comb
  begin
    data_o = 8'h00;
    case (addr_i)
      memmap_pkg::SIG_ID0:       data_o = PART_ID[7:0];
      memmap_pkg::SIG_ID1:       data_o = PART_ID[15:8];
      memmap_pkg::SIG_ID2:       data_o = PART_ID[23:16];
      memmap_pkg::SIG_TGAIN:     data_o = TGAIN[7:0];
      memmap_pkg::SIG_TGAIN + 5'h01: data_o = TGAIN[15:8];
      memmap_pkg::SIG_TOFF:      data_o = TOFF[7:0];
      memmap_pkg::SIG_TOFF + 5'h01:  data_o = TOFF[15:8];
      default:
      begin
        if (addr_i >= memmap_pkg::SIG_SER0)
          data_o = SERIAL[{addr_i[3:0], 3'b000} +: 8];
      end
    endcase
  end

endmodule : signature_rom

/* design/flash_array.sv */
// Program flash storage: 16-bit words, fetch port and byte access port
`timescale 1ns/1ps
module flash_array (
  input  wire logic        clk_i,    // System clock
  input  wire logic        rst_i,    // Async reset, active high
  input  wire logic [14:0] f_addr_i, // Fetch word address
  output logic      [15:0] f_q_o,    // Fetched word
  input  wire logic [14:0] b_addr_i, // Byte port word address
  input  wire logic        b_we_i,   // Byte write strobe
  input  wire logic        b_lane_i, // 1 selects the high byte
  input  wire logic [7:0]  b_wd_i,   // Write byte
  output logic      [15:0] b_q_o     // Read word
);

  logic [15:0] mem [memmap_pkg::FLASH_WORDS];

  always_ff @(posedge clk_i)
  begin
    if (b_we_i)
    begin
      if (b_lane_i)
        mem[b_addr_i][15:8] <= b_wd_i;
      else
        mem[b_addr_i][7:0] <= b_wd_i;
    end
  end

  // Both ports read the whole array; fetch has its own port
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      f_q_o <= 16'h0000;
      b_q_o <= 16'h0000;
    end
    else
    begin
      f_q_o <= mem[f_addr_i];
      b_q_o <= mem[b_addr_i];
    end
  end

endmodule : flash_array

/* design/memory_map_decoder.sv */
// Data and code space decoder with flash window and signature row
//
// Notes on behaviour
// - Program flash is held as 16-bit words.
// - Flash is 64 KB, 128 pages of 512 bytes.
// - Flash splits into boot, application code and data regions; boot may write app and data, app only data, others blocked.
// - Fetch address reaches every flash word.
// - Selected 32 KB flash half appears at data 0x8000 to 0xffff.
// - Program memory loads and stores reach all flash from code address 0.
// - 8 KB SRAM decoded from 0x6000; stack starts at its top.
// - Instructions are fetched only from flash, never SRAM.
// - 512-byte EEPROM at 0x1400, byte accesses in any run length.
// - EEPROM accesses go through the nonvolatile controller.
// - Peripheral registers live in the I/O part of data space.
// - Signature row is read-only; writes leave it unchanged.
// - Three part identifier bytes at 0x00 to 0x02, readable when locked.
// - Calibration words at 0x04, 0x06; sixteen serial bytes from 0x10.
`timescale 1ns/1ps
module memory_map_decoder #(
  parameter logic [23:0]  PART_ID = 24'h00a5c3,  // Arbitrary value
  parameter logic [15:0]  TGAIN   = 16'h0100,    // Arbitrary value
  parameter logic [15:0]  TOFF    = 16'h0000,    // Arbitrary value
  parameter logic [127:0] SERIAL  = 128'h0       // Arbitrary value
) (
  input  wire logic                 clk_i,       // System clock
  input  wire logic                 rst_i,       // Async reset
  input  wire logic                 req_i,       // CPU access request
  input  wire memmap_pkg::cpu_req_t req_d_i,     // CPU access fields
  output logic                      ready_o,     // Idle, can take a request
  output logic                      rsp_valid_o, // Access done pulse
  output logic      [7:0]           rsp_data_o,  // Read byte
  output logic                      blocked_o,   // Flash write refused
  input  wire logic                 fetch_i,     // Fetch request
  input  wire logic [14:0]          fetch_pc_i,  // Word program counter
  output logic                      fetch_vld_o, // Fetch word valid
  output logic      [15:0]          fetch_ins_o, // Fetched word
  input  wire logic [7:0]           boot_len_i,  // Boot region pages
  input  wire logic [7:0]           app_len_i,   // App code pages
  output logic                      ext_req_o,   // Outside access
  output memmap_pkg::ext_req_t      ext_d_o,     // Outside access fields
  input  wire logic                 ext_ack_i,   // Outside access done
  input  wire logic [7:0]           ext_rd_i,    // Outside read byte
  input  wire logic                 dbg_req_i,   // Debug signature read
  input  wire logic [4:0]           dbg_addr_i,  // Signature offset
  output logic                      dbg_vld_o,   // Debug answer pulse
  output logic      [7:0]           dbg_data_o,  // Debug answer byte
  output logic      [15:0]          stack_top_o  // Initial stack pointer
);

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  memmap_pkg::acc_state_t state_r;
  memmap_pkg::region_t    rg;
  memmap_pkg::region_t    rg_r;
  memmap_pkg::ext_req_t   ext_r;
  memmap_pkg::prot_t      src_pr;
  memmap_pkg::prot_t      dst_pr;
  logic                   take;
  logic                   win_sel_r;
  logic [14:0]            last_pc_r;
  logic [14:0]            fl_addr;
  logic                   fl_target;
  logic                   wr_ok;
  logic                   fl_we;
  logic                   sram_we;
  logic [15:0]            fl_q;
  logic [7:0]             sram_q_r;
  logic [7:0]             sig_cpu;
  logic [7:0]             sig_dbg;
  logic [7:0]             rd_mux;
  logic [7:0]             sram [memmap_pkg::SRAM_BYTES];
  logic                   lane_r;
  logic [4:0]             sig_off_r;
  logic                   blocked_nxt;

  assign ready_o     = (state_r == memmap_pkg::ST_IDLE);
  assign take        = req_i && ready_o;
  assign ext_req_o   = (state_r == memmap_pkg::ST_EXT);
  assign ext_d_o     = ext_r;
  assign stack_top_o = memmap_pkg::SRAM_END;

  // Code space covers the whole flash; data space only the window
  always_comb
  begin
    if (req_d_i.code)
    begin
      rg      = memmap_pkg::RG_FLASH;
      fl_addr = req_d_i.addr[15:1];
    end
    else
    begin
      rg      = memmap_pkg::decode(req_d_i.addr);
      fl_addr = {win_sel_r, req_d_i.addr[14:1]};
    end
  end

  // ----------------------------------------------------------------
  // Flash write protection
  // ----------------------------------------------------------------
  always_comb
  begin
    src_pr = memmap_pkg::prot_region(last_pc_r[14:8], boot_len_i,
                                     app_len_i);
    dst_pr = memmap_pkg::prot_region(fl_addr[14:8], boot_len_i,
                                     app_len_i);
    case (src_pr)
      memmap_pkg::PR_BOOT: wr_ok = (dst_pr != memmap_pkg::PR_BOOT);
      memmap_pkg::PR_APP:  wr_ok = (dst_pr == memmap_pkg::PR_DATA);
      default:             wr_ok = 1'b0;
    endcase
  end

  assign fl_target   = take && req_d_i.we && (rg == memmap_pkg::RG_FLASH);
  assign fl_we       = fl_target && wr_ok;
  assign blocked_nxt = fl_target && !wr_ok;
  assign sram_we     = take && req_d_i.we &&
                       (rg == memmap_pkg::RG_SRAM);

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      blocked_o <= 1'b0;
    else
      blocked_o <= blocked_nxt;
  end

  // Writer region follows the word the CPU last fetched
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      last_pc_r <= 15'h0000;
    else if (fetch_i)
      last_pc_r <= fetch_pc_i;
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  flash_array u_flash (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .f_addr_i (fetch_pc_i),
    .f_q_o    (fetch_ins_o),
    .b_addr_i (fl_addr),
    .b_we_i   (fl_we),
    .b_lane_i (req_d_i.addr[0]),
    .b_wd_i   (req_d_i.wdata),
    .b_q_o    (fl_q)
  );

  // SRAM holds data only; no path leads from it to the fetch word
  always_ff @(posedge clk_i)
  begin
    if (sram_we)
      sram[req_d_i.addr[12:0]] <= req_d_i.wdata;
    sram_q_r <= sram[req_d_i.addr[12:0]];
  end

  signature_rom #(
    .PART_ID (PART_ID),
    .TGAIN   (TGAIN),
    .TOFF    (TOFF),
    .SERIAL  (SERIAL)
  ) u_sig_cpu (
    .addr_i (sig_off_r),
    .data_o (sig_cpu)
  );

  signature_rom #(
    .PART_ID (PART_ID),
    .TGAIN   (TGAIN),
    .TOFF    (TOFF),
    .SERIAL  (SERIAL)
  ) u_sig_dbg (
    .addr_i (dbg_addr_i),
    .data_o (sig_dbg)
  );

  // ----------------------------------------------------------------
  // Window select register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      win_sel_r <= memmap_pkg::WIN_SEL_RST;
    else if (take && req_d_i.we && rg == memmap_pkg::RG_CFG)
      win_sel_r <= req_d_i.wdata[0];
  end

  // ----------------------------------------------------------------
  // Access sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      state_r <= memmap_pkg::ST_IDLE;
    else
    begin
      case (state_r)
        memmap_pkg::ST_IDLE:
        begin
          if (take && (rg == memmap_pkg::RG_IO ||
                       rg == memmap_pkg::RG_EE))
            state_r <= memmap_pkg::ST_EXT;
          else if (take)
            state_r <= memmap_pkg::ST_LOCAL;
        end
        memmap_pkg::ST_LOCAL: state_r <= memmap_pkg::ST_IDLE;
        memmap_pkg::ST_EXT:
        begin
          if (ext_ack_i)
            state_r <= memmap_pkg::ST_IDLE;
        end
        default: state_r <= memmap_pkg::ST_IDLE;
      endcase
    end
  end

  // Peripheral and EEPROM fields held until the acknowledge
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ext_r <= '0;
    else if (take)
    begin
      ext_r.io    <= (rg == memmap_pkg::RG_IO);
      ext_r.ee    <= (rg == memmap_pkg::RG_EE);
      ext_r.we    <= req_d_i.we;
      ext_r.addr  <= (rg == memmap_pkg::RG_EE) ?
                     (req_d_i.addr - memmap_pkg::EE_BASE) :
                     req_d_i.addr;
      ext_r.wdata <= req_d_i.wdata;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rg_r      <= memmap_pkg::RG_NONE;
      lane_r    <= 1'b0;
      sig_off_r <= 5'h00;
    end
    else if (take)
    begin
      rg_r      <= rg;
      lane_r    <= req_d_i.addr[0];
      sig_off_r <= req_d_i.addr[4:0];
    end
  end

  // Unmapped and write-only holes read zero
  always_comb
  begin
    case (rg_r)
      memmap_pkg::RG_CFG:   rd_mux = {7'h00, win_sel_r};
      memmap_pkg::RG_SIG:   rd_mux = sig_cpu;
      memmap_pkg::RG_SRAM:  rd_mux = sram_q_r;
      memmap_pkg::RG_FLASH: rd_mux = lane_r ? fl_q[15:8] : fl_q[7:0];
      default:              rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rsp_valid_o <= 1'b0;
      rsp_data_o  <= 8'h00;
    end
    else
    begin
      rsp_valid_o <= (state_r == memmap_pkg::ST_LOCAL) ||
                     (ext_req_o && ext_ack_i);
      if (state_r == memmap_pkg::ST_LOCAL)
        rsp_data_o <= rd_mux;
      else if (ext_req_o && ext_ack_i)
        rsp_data_o <= ext_r.we ? 8'h00 : ext_rd_i;
    end
  end

  // ----------------------------------------------------------------
  // Fetch and debug answers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fetch_vld_o <= 1'b0;
      dbg_vld_o   <= 1'b0;
      dbg_data_o  <= 8'h00;
    end
    else
    begin
      fetch_vld_o <= fetch_i;
      dbg_vld_o   <= dbg_req_i;
      if (dbg_req_i)
        dbg_data_o <= sig_dbg;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_LOCAL_TWO: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && rg != memmap_pkg::RG_IO && rg != memmap_pkg::RG_EE) |=>
    (state_r == memmap_pkg::ST_LOCAL) ##1 (rsp_valid_o && ready_o))
    else $error("local access did not finish in two cycles");

  AST_WIN_MAP: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && !req_d_i.code && rg == memmap_pkg::RG_FLASH) |->
    fl_addr == {win_sel_r, req_d_i.addr[14:1]})
    else $error("window address wrong");

  AST_CODE_MAP: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && req_d_i.code) |-> (fl_addr == req_d_i.addr[15:1]))
    else $error("code address wrong");

  AST_EE_ROUTE: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && rg == memmap_pkg::RG_EE) |=> ext_req_o && ext_r.ee &&
    ext_r.addr == ($past(req_d_i.addr) - memmap_pkg::EE_BASE))
    else $error("eeprom access not forwarded");

  AST_EXT_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    (ext_req_o && !ext_ack_i) |=> ext_req_o && $stable(ext_r))
    else $error("outside access dropped before ack");

  AST_PROT: assert property (@(posedge clk_i) disable iff (rst_i)
    (fl_target && !wr_ok) |-> !fl_we ##1 blocked_o)
    else $error("protected flash write let through");

  AST_SIG_RO: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && req_d_i.we && rg == memmap_pkg::RG_SIG) |->
    !fl_we && !sram_we ##1 !blocked_o)
    else $error("signature write reached storage");

  AST_DBG_ID: assert property (@(posedge clk_i) disable iff (rst_i)
    (dbg_req_i && dbg_addr_i == memmap_pkg::SIG_ID2) |=>
    dbg_vld_o && dbg_data_o == PART_ID[23:16])
    else $error("part identifier byte wrong");

  AST_RSV_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    (dbg_req_i && (dbg_addr_i == 5'h03 || (dbg_addr_i >= 5'h08 &&
     dbg_addr_i < memmap_pkg::SIG_SER0))) |=> dbg_data_o == 8'h00)
    else $error("reserved signature byte not zero");

  AST_CAL_WORD: assert property (@(posedge clk_i) disable iff (rst_i)
    (dbg_req_i && dbg_addr_i == memmap_pkg::SIG_TOFF) ##1
    (dbg_req_i && dbg_addr_i == memmap_pkg::SIG_TOFF + 5'h01) |=>
    {dbg_data_o, $past(dbg_data_o)} == TOFF)
    else $error("calibration word wrong");

  AST_SRAM_WE: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && !req_d_i.code && req_d_i.addr >= memmap_pkg::SRAM_BASE &&
     req_d_i.addr <= memmap_pkg::SRAM_END) |-> sram_we == req_d_i.we)
    else $error("sram decode wrong");

  AST_WIN_CFG: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && req_d_i.we && !req_d_i.code &&
     req_d_i.addr == memmap_pkg::CFG_ADDR) |=>
    win_sel_r == $past(req_d_i.wdata[0]))
    else $error("window select not updated");

endmodule : memory_map_decoder

/* tb/ext_model.sv */
// Behavioural responder for forwarded I/O and EEPROM accesses
`timescale 1ns/1ps
module ext_model (
  input  wire logic                 clk_i,     // System clock
  input  wire logic                 rst_i,     // Async reset
  input  wire logic                 slow_i,    // Stretch the answer
  input  wire logic                 ext_req_i, // Outside access
  input  wire memmap_pkg::ext_req_t ext_d_i,   // Access fields
  output logic                      ext_ack_o, // Access done
  output logic      [7:0]           ext_rd_o   // Read byte
);
  logic [7:0]  mem [0:8191];
  logic [7:0]  last_r;
  logic [2:0]  wait_r;
  logic [12:0] idx;
  assign idx = {ext_d_i.ee, ext_d_i.addr[11:0]};
  // Idle bus shows the inverse so a stale byte cannot pass
  assign ext_rd_o = ext_ack_o ? mem[idx] : ~last_r;
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      ext_ack_o <= 1'b0;
      wait_r    <= 3'h0;
      last_r    <= 8'h00;
    end
    else if (ext_ack_o)
    begin
      ext_ack_o <= 1'b0;
      wait_r    <= 3'h0;
      last_r    <= ext_rd_o;
      if (ext_d_i.we)
        mem[idx] <= ext_d_i.wdata;
    end
    else if (ext_req_i)
    begin
      wait_r    <= wait_r + 3'h1;
      ext_ack_o <= !slow_i || wait_r == 3'h3;
    end
endmodule : ext_model

/* tb/memory_map_decoder_tb.sv */
// Self-checking bench for the memory map decoder
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module memory_map_decoder_tb;
  localparam logic [23:0]  P_ID = 24'h5a3c71;  // Arbitrary value
  localparam logic [15:0]  P_TG = 16'hb2e4;
  localparam logic [15:0]  P_TO = 16'h7d19;
  localparam logic [127:0] P_SN = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
  logic                 clk_i = 1'b0;
  logic                 rst_i, req_i = 1'b0, fetch_i = 1'b0;
  logic                 dbg_req_i = 1'b0, slow = 1'b0, blk;
  memmap_pkg::cpu_req_t req_d_i = '0;
  memmap_pkg::ext_req_t ext_d_o;
  logic [14:0]          fetch_pc_i = '0;
  logic [7:0]           boot_len_i = 8'h01, app_len_i = 8'h00;
  logic [4:0]           dbg_addr_i = '0;
  logic                 ready_o, rsp_valid_o, blocked_o, fetch_vld_o;
  logic                 ext_req_o, ext_ack_i, dbg_vld_o;
  logic [7:0]           rsp_data_o, ext_rd_i, dbg_data_o, rd;
  logic [15:0]          fetch_ins_o, stack_top_o;
  logic [31:0]          seed = 32'h84aa, r;
  logic [7:0]           sh [logic [15:0]];
  logic [15:0]          ea [5] = '{16'h1400, 16'h1401, 16'h15ff,
                                   16'h0000, 16'h0fff};
  logic [7:0]           ed [5];
  int                   miscompares = 0, n_compared = 0, cyc = 0;

  memory_map_decoder #(.PART_ID(P_ID), .TGAIN(P_TG), .TOFF(P_TO),
    .SERIAL(P_SN)) memory_map_decoder_i (.clk_i(clk_i), .rst_i(rst_i),
    .req_i(req_i), .req_d_i(req_d_i), .ready_o(ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
    .blocked_o(blocked_o), .fetch_i(fetch_i), .fetch_pc_i(fetch_pc_i),
    .fetch_vld_o(fetch_vld_o), .fetch_ins_o(fetch_ins_o),
    .boot_len_i(boot_len_i), .app_len_i(app_len_i), .ext_req_o(ext_req_o),
    .ext_d_o(ext_d_o), .ext_ack_i(ext_ack_i), .ext_rd_i(ext_rd_i),
    .dbg_req_i(dbg_req_i), .dbg_addr_i(dbg_addr_i), .dbg_vld_o(dbg_vld_o),
    .dbg_data_o(dbg_data_o), .stack_top_o(stack_top_o));
  ext_model ext_model_i (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
    .ext_req_i(ext_req_o), .ext_d_i(ext_d_o), .ext_ack_o(ext_ack_i),
    .ext_rd_o(ext_rd_i));

  always #50 clk_i = ~clk_i;
  // Whole run needs well under 3000 cycles
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      complete_run();
    end
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [7:0] sig_exp(input logic [4:0] o);
    case (o)
      5'h00, 5'h01, 5'h02: return P_ID[8*o +: 8];
      5'h04, 5'h05:        return P_TG[8*(o-4) +: 8];
      5'h06, 5'h07:        return P_TO[8*(o-6) +: 8];
      default:             return o[4] ? P_SN[8*o[3:0] +: 8] : 8'h00;
    endcase
  endfunction : sig_exp

  task automatic do_reset();
    rst_i = 1'b1;
    repeat (8) @(negedge clk_i);
    `CHK(rsp_valid_o, 1'b0)
    `CHK(stack_top_o, 16'h7fff)
    rst_i = 1'b0;
  endtask : do_reset

  // One byte access; idle decoder takes it at the next edge
  task automatic acc(input logic c, input logic w, input logic [15:0] a,
                     input logic [7:0] d);
    int n;
    logic ex;
    ex      = !c && (a <= 16'h0fff || (a >= 16'h1400 && a <= 16'h15ff));
    req_i   = 1'b1;
    req_d_i = '{code: c, we: w, addr: a, wdata: d};
    @(negedge clk_i);
    req_i = 1'b0;
    blk   = blocked_o;
    n     = 0;
    `CHK(ready_o, 1'b0)
    `CHK(ext_req_o, ex)
    while (rsp_valid_o !== 1'b1 && n < 50)
    begin
      @(negedge clk_i);
      n++;
    end
    `CHK(rsp_valid_o, 1'b1)
    rd = rsp_data_o;
  endtask : acc

  task automatic fch(input logic [14:0] pc, input logic c,
                     input logic [15:0] e);
    fetch_i    = 1'b1;
    fetch_pc_i = pc;
    @(negedge clk_i);
    fetch_i = 1'b0;
    `CHK(fetch_vld_o, 1'b1)
    if (c)
      `CHK(fetch_ins_o, e)
  endtask : fch

  task automatic dbg(input logic [4:0] o);
    dbg_req_i  = 1'b1;
    dbg_addr_i = o;
    @(negedge clk_i);
    dbg_req_i = 1'b0;
    `CHK(dbg_vld_o, 1'b1)
    `CHK(dbg_data_o, sig_exp(o))
  endtask : dbg

  task automatic complete_run();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  initial
  begin
    do_reset();
    repeat (16)
    begin
      r = xs();
      acc(1'b0, 1'b1, {3'b011, r[12:0]}, r[20:13]);
      sh[{3'b011, r[12:0]}] = r[20:13];
    end
    foreach (sh[k])
    begin
      acc(1'b0, 1'b0, k, 8'h00);
      `CHK(rd, sh[k])
    end
    fch(15'h0000, 1'b0, 16'h0000);
    acc(1'b1, 1'b1, 16'h0400, 8'h3c);
    acc(1'b1, 1'b1, 16'h0402, 8'h5a);
    acc(1'b1, 1'b1, 16'hc400, 8'ha7);
    acc(1'b1, 1'b1, 16'hfffe, 8'h11);
    acc(1'b1, 1'b1, 16'hffff, 8'h22);
    acc(1'b1, 1'b1, 16'h6000, 8'h44);
    acc(1'b1, 1'b1, 16'h6001, 8'h55);
    acc(1'b0, 1'b1, 16'h6000, 8'h99);
    acc(1'b0, 1'b0, 16'h8400, 8'h00);
    `CHK(rd, 8'h3c)
    acc(1'b1, 1'b0, 16'h0400, 8'h00);
    `CHK(rd, 8'h3c)
    acc(1'b0, 1'b1, 16'h1000, 8'h01);
    acc(1'b0, 1'b0, 16'h1000, 8'h00);
    `CHK(rd, 8'h01)
    acc(1'b0, 1'b0, 16'h2000, 8'h00);
    `CHK(rd, 8'h00)
    acc(1'b0, 1'b0, 16'hc400, 8'h00);
    `CHK(rd, 8'ha7)
    fch(15'h7fff, 1'b1, 16'h2211);
    fch(15'h3000, 1'b1, 16'h5544);
    // Writer now sits in the data region, so the store is refused
    acc(1'b1, 1'b1, 16'h0402, 8'hff);
    `CHK(blk, 1'b1)
    acc(1'b1, 1'b0, 16'h0402, 8'h00);
    `CHK(rd, 8'h5a)
    fch(15'h0000, 1'b0, 16'h0000);
    acc(1'b1, 1'b1, 16'h0402, 8'h66);
    `CHK(blk, 1'b0)
    do_reset();
    acc(1'b0, 1'b0, 16'h8400, 8'h00);
    `CHK(rd, 8'h3c)
    for (int i = 0; i < 5; i++)
    begin
      r     = xs();
      slow  = r[0];
      ed[i] = r[15:8];
      acc(1'b0, 1'b1, ea[i], ed[i]);
    end
    `CHK(ext_model_i.mem[13'h1001], ed[1])
    for (int i = 0; i < 5; i++)
    begin
      r    = xs();
      slow = r[0];
      acc(1'b0, 1'b0, ea[i], 8'h00);
      `CHK(rd, ed[i])
    end
    for (int o = 0; o < 32; o++)
    begin
      acc(1'b0, 1'b1, 16'(16'h1100 + o), ~sig_exp(o[4:0]));
      dbg(o[4:0]);
      acc(1'b0, 1'b0, 16'(16'h1100 + o), 8'h00);
      `CHK(rd, sig_exp(o[4:0]))
    end
    complete_run();
  end
endmodule : memory_map_decoder_tb
